// ### hw/ufi_pkg.sv
package ufi_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IDENT_FIFO_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FRAME_CFG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_LINE_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SCRATCH = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FCR_ENABLE = 0;
  localparam int FCR_RX_CLEAR = 1;
  localparam int FCR_TX_CLEAR = 2;
  localparam int FCR_TRIG_LO = 6;
  localparam int FCR_TRIG_HI = 7;
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LINE = 2;
  localparam int ENT_PARITY = 8;
  localparam int ENT_FRAME = 9;
  localparam int ENT_BREAK = 10;

  // ----------------------------------------------------------------
  // sizes, reset values, timing
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam int ENT_W = 11;
  localparam int TMR_W = 10;
  localparam logic [CNT_W-1:0] DEPTH_FIFO = 5'h10;
  localparam logic [CNT_W-1:0] DEPTH_CHAR = 5'h01;
  localparam logic [3:0] FRAME_RESET = 4'ha;
  localparam logic [3:0] IER_RESET = 4'h0;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  // rclk ticks per bit (16x clock) and four character times
  localparam int BIT_SHIFT = 4;
  localparam int TIMEOUT_SHIFT = 6;

  // ----------------------------------------------------------------
  // receive trigger levels and identification codes
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] TRIG_00 = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_01 = 5'h04;
  localparam logic [CNT_W-1:0] TRIG_10 = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_11 = 5'h0e;
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_LINE = 4'h6;
  localparam logic [3:0] ID_RXDATA = 4'h4;
  localparam logic [3:0] ID_TIMEOUT = 4'hc;
  localparam logic [3:0] ID_TXEMPTY = 4'h2;

  typedef logic [ADDR_W-1:0] ufi_addr_t;
  typedef logic [31:0] ufi_word_t;
  typedef logic [7:0] ufi_byte_t;

endpackage

// ### hw/ufi_fifo_irq.sv
// Operation
// - eight-bit scratch register stores and returns software data, affects nothing else
// - receive data interrupt high while fill at or above trigger level
// - identification shows receive data exactly while fill meets trigger
// - line status code 06 wins over receive data code 04
// - data ready set on character entry, cleared only when receive fifo empty
// - timeout when fifo nonempty and over four character times idle
// - character times counted on receiver clock ticks, scaling with baud
// - active timeout cleared and timer restarted by one host read
// - inactive timer restarts on new character or host read
// - transmit empty code 02 set when empty, cleared by write or identification read
// - empty indication delayed one character less stop bit unless two bytes held
// - first transmit interrupt after fifo enable change is immediate
// - timeout and trigger share receive priority, fifo empty shares transmit priority
// - cleared enable bits give polled mode, receiver and transmitter independently
// - polled mode reports character errors as usual, identification unaffected
// - holding empty flag set whenever transmit fifo empty
// - transmitter empty flag needs transmit fifo and shift register both empty
// - receive fifo error flag set while any held character has an error
// - polled mode shows no trigger or timeout, fifos still buffer fully
// - trigger bits select 1, 4, 8 or 14 bytes
// - identification bit 3 set with bit 2 on timeout, zero without fifos
// - enable bit 0 gates receive data and timeout interrupts
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module ufi_fifo_irq (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire ufi_pkg::ufi_addr_t paddr,
  input wire ufi_pkg::ufi_word_t pwdata,
  output logic pready,
  output ufi_pkg::ufi_word_t prdata,
  output logic pslverr,
  input wire logic rclkPin,
  input wire logic rxPush,
  input wire ufi_pkg::ufi_byte_t rxByte,
  input wire logic rxParityErr,
  input wire logic rxFrameErr,
  input wire logic rxBreak,
  input wire logic txPull,
  input wire logic txShiftBusy,
  output ufi_pkg::ufi_byte_t txByte,
  output logic txAvail,
  output logic irqOut
);
  import ufi_pkg::*;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire setupPh = psel & ~penable;
  wire accessPh = psel & penable;
  wire wrEn = accessPh & pwrite;
  wire rdEn = accessPh & ~pwrite;
  wire hitData = (paddr == OFS_DATA);
  wire hitIer = (paddr == OFS_IRQ_ENABLE);
  wire hitIdent = (paddr == OFS_IDENT_FIFO_CTRL);
  wire hitCfg = (paddr == OFS_FRAME_CFG);
  wire hitLsr = (paddr == OFS_LINE_STATUS);
  wire hitScr = (paddr == OFS_SCRATCH);
  wire mapped = hitData | hitIer | hitIdent | hitCfg | hitLsr | hitScr;
  wire wrData = wrEn & hitData;
  wire rdData = rdEn & hitData;
  wire wrFcr = wrEn & hitIdent;
  wire rdIdent = rdEn & hitIdent;
  wire rdLsr = rdEn & hitLsr;

  logic [7:0] scratch_r;
  logic [3:0] ier_r;
  logic fifoEn_r;
  logic [1:0] trig_r;
  logic [3:0] frame_r;
  logic prevIerTx_r;

  wire fcrChange = wrFcr & (pwdata[FCR_ENABLE] != fifoEn_r);
  wire rxClr = wrFcr & (pwdata[FCR_RX_CLEAR] | fcrChange);
  wire txClr = wrFcr & (pwdata[FCR_TX_CLEAR] | fcrChange);
  wire [CNT_W-1:0] capacity = fifoEn_r ? DEPTH_FIFO : DEPTH_CHAR;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      scratch_r <= SCRATCH_RESET;
      ier_r <= IER_RESET;
      fifoEn_r <= 1'b0;
      trig_r <= 2'b00;
      frame_r <= FRAME_RESET;
      prevIerTx_r <= 1'b0;
    end
    else
    begin
      prevIerTx_r <= ier_r[IER_TX];
      if (wrEn & hitScr)
        scratch_r <= pwdata[7:0];
      if (wrEn & hitIer)
        ier_r <= pwdata[3:0];
      if (wrEn & hitCfg)
        frame_r <= pwdata[3:0];
      if (wrFcr)
      begin
        fifoEn_r <= pwdata[FCR_ENABLE];
        trig_r <= {pwdata[FCR_TRIG_HI], pwdata[FCR_TRIG_LO]};
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver clock sampling
  // ----------------------------------------------------------------
  logic rclkS1_r;
  logic rclkS2_r;
  logic rclkS3_r;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rclkS1_r <= 1'b0;
      rclkS2_r <= 1'b0;
      rclkS3_r <= 1'b0;
    end
    else
    begin
      rclkS1_r <= rclkPin;
      rclkS2_r <= rclkS1_r;
      rclkS3_r <= rclkS2_r;
    end
  end
  wire rclkTick = rclkS2_r & ~rclkS3_r;

  // ----------------------------------------------------------------
  // receive fifo
  // ----------------------------------------------------------------
  logic [ENT_W-1:0] rxMem [FIFO_DEPTH];
  logic [PTR_W-1:0] rxWp_r;
  logic [PTR_W-1:0] rxRp_r;
  logic [CNT_W-1:0] rxCnt_r;
  logic [CNT_W-1:0] rxErrCnt_r;
  logic overrun_r;

  wire rxFull = (rxCnt_r >= capacity);
  wire rxDo = rxPush & ~rxFull & ~rxClr;
  wire rxPop = rdData & (rxCnt_r != 5'h00) & ~rxClr;
  wire [ENT_W-1:0] rxHead = rxMem[rxRp_r];
  wire inErr = rxParityErr | rxFrameErr | rxBreak;
  wire headErr = rxHead[ENT_PARITY] | rxHead[ENT_FRAME] | rxHead[ENT_BREAK];
  wire [CNT_W-1:0] rxCnt_nxt = rxCnt_r + {4'h0, rxDo} - {4'h0, rxPop};
  wire [CNT_W-1:0] rxErr_nxt = rxErrCnt_r + {4'h0, rxDo & inErr} - {4'h0, rxPop & headErr};

  always_ff @(posedge clk_sys)
  begin
    if (rxDo)
      rxMem[rxWp_r] <= {rxBreak, rxFrameErr, rxParityErr, rxByte};
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rxWp_r <= 4'h0;
      rxRp_r <= 4'h0;
      rxCnt_r <= 5'h00;
      rxErrCnt_r <= 5'h00;
      overrun_r <= 1'b0;
    end
    else
    begin
      if (rxClr)
      begin
        rxWp_r <= 4'h0;
        rxRp_r <= 4'h0;
        rxCnt_r <= 5'h00;
        rxErrCnt_r <= 5'h00;
      end
      else
      begin
        if (rxDo)
          rxWp_r <= rxWp_r + 4'h1;
        if (rxPop)
          rxRp_r <= rxRp_r + 4'h1;
        rxCnt_r <= rxCnt_nxt;
        rxErrCnt_r <= rxErr_nxt;
      end
      // set wins over the clear by status read
      if (rxPush & rxFull)
        overrun_r <= 1'b1;
      else if (rdLsr)
        overrun_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // receive interrupts and timeout
  // ----------------------------------------------------------------
  wire [CNT_W-1:0] trigLevel = (trig_r == 2'b00) ? TRIG_00 :
                               (trig_r == 2'b01) ? TRIG_01 :
                               (trig_r == 2'b10) ? TRIG_10 : TRIG_11;
  wire [CNT_W-1:0] rxLevel = fifoEn_r ? trigLevel : DEPTH_CHAR;
  wire dataReady = (rxCnt_r != 5'h00);
  wire rxDataIrq = ier_r[IER_RX] & (rxCnt_r >= rxLevel);
  wire lineIrq = ier_r[IER_LINE] & (overrun_r | (dataReady & headErr));

  logic [TMR_W-1:0] toCnt_r;
  logic toActive_r;
  wire [TMR_W-1:0] toLimit = TMR_W'(frame_r) << TIMEOUT_SHIFT;
  wire toExpired = (toCnt_r > toLimit) & dataReady & fifoEn_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      toCnt_r <= 10'h000;
      toActive_r <= 1'b0;
    end
    else if (rxClr | ~fifoEn_r)
    begin
      toCnt_r <= 10'h000;
      toActive_r <= 1'b0;
    end
    else if (toActive_r)
    begin
      if (rxPop)
      begin
        toActive_r <= 1'b0;
        toCnt_r <= 10'h000;
      end
    end
    else if (rxDo | rxPop)
      toCnt_r <= 10'h000;
    else
    begin
      if (rclkTick & (toCnt_r != 10'h3ff))
        toCnt_r <= toCnt_r + 10'h001;
      if (toExpired)
        toActive_r <= 1'b1;
    end
  end
  wire timeoutIrq = ier_r[IER_RX] & toActive_r;

  // ----------------------------------------------------------------
  // transmit fifo
  // ----------------------------------------------------------------
  logic [7:0] txMem [FIFO_DEPTH];
  logic [PTR_W-1:0] txWp_r;
  logic [PTR_W-1:0] txRp_r;
  logic [CNT_W-1:0] txCnt_r;

  wire txDo = wrData & (txCnt_r < capacity) & ~txClr;
  wire txPop = txPull & (txCnt_r != 5'h00) & ~txClr;
  wire [CNT_W-1:0] txCnt_nxt = txCnt_r + {4'h0, txDo} - {4'h0, txPop};

  always_ff @(posedge clk_sys)
  begin
    if (txDo)
      txMem[txWp_r] <= pwdata[7:0];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      txWp_r <= 4'h0;
      txRp_r <= 4'h0;
      txCnt_r <= 5'h00;
    end
    else if (txClr)
    begin
      txWp_r <= 4'h0;
      txRp_r <= 4'h0;
      txCnt_r <= 5'h00;
    end
    else
    begin
      if (txDo)
        txWp_r <= txWp_r + 4'h1;
      if (txPop)
        txRp_r <= txRp_r + 4'h1;
      txCnt_r <= txCnt_nxt;
    end
  end
  assign txByte = txMem[txRp_r];
  assign txAvail = (txCnt_r != 5'h00);

  // ----------------------------------------------------------------
  // transmit empty indication
  // ----------------------------------------------------------------
  wire holding_empty_condition = (txCnt_r == 5'h00);
  wire txAllEmpty = holding_empty_condition & ~txShiftBusy;
  logic threD_r;
  logic twoHeld_r;
  logic skipDly_r;
  logic dlyRun_r;
  logic [TMR_W-1:0] dlyCnt_r;
  logic txPend_r;
  logic identTx_r;

  wire threRise = holding_empty_condition & ~threD_r;
  wire immediate = ~fifoEn_r | twoHeld_r | skipDly_r;
  wire [TMR_W-1:0] dlyLimit = TMR_W'(4'(frame_r - 4'h1)) << BIT_SHIFT;
  wire dlyDone = dlyRun_r & rclkTick & (dlyCnt_r >= dlyLimit);
  wire ierTxRise = ier_r[IER_TX] & ~prevIerTx_r;
  wire txSet = (threRise & immediate) | (dlyDone & holding_empty_condition) | (ierTxRise & holding_empty_condition);
  wire txClrEvt = wrData | (rdIdent & identTx_r);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      threD_r <= 1'b1;
      twoHeld_r <= 1'b0;
      skipDly_r <= 1'b0;
      dlyRun_r <= 1'b0;
      dlyCnt_r <= 10'h000;
      txPend_r <= 1'b0;
    end
    else
    begin
      threD_r <= holding_empty_condition;
      if (txCnt_r >= 5'h02)
        twoHeld_r <= 1'b1;
      else if (threRise)
        twoHeld_r <= 1'b0;
      if (fcrChange)
        skipDly_r <= 1'b1;
      else if (txSet)
        skipDly_r <= 1'b0;
      if (threRise & ~immediate)
      begin
        dlyRun_r <= 1'b1;
        dlyCnt_r <= 10'h000;
      end
      else if (~holding_empty_condition | dlyDone)
        dlyRun_r <= 1'b0;
      else if (dlyRun_r & rclkTick)
        dlyCnt_r <= dlyCnt_r + 10'h001;
      if (txSet)
        txPend_r <= 1'b1;
      else if (txClrEvt)
        txPend_r <= 1'b0;
    end
  end
  wire txIrq = ier_r[IER_TX] & txPend_r;

  // ----------------------------------------------------------------
  // identification, status and read data
  // ----------------------------------------------------------------
  wire [3:0] idCode = lineIrq ? ID_LINE :
                      rxDataIrq ? ID_RXDATA :
                      timeoutIrq ? ID_TIMEOUT :
                      txIrq ? ID_TXEMPTY : ID_NONE;
  wire [7:0] identVal = {fifoEn_r, fifoEn_r, 2'b00, idCode};
  wire [7:0] lsrVal = {fifoEn_r & (rxErrCnt_r != 5'h00), txAllEmpty, holding_empty_condition,
                       dataReady & rxHead[ENT_BREAK], dataReady & rxHead[ENT_FRAME],
                       dataReady & rxHead[ENT_PARITY], overrun_r, dataReady};
  wire [7:0] rdMux = hitData ? rxHead[7:0] :
                     hitIer ? {4'h0, ier_r} :
                     hitIdent ? identVal :
                     hitCfg ? {4'h0, frame_r} :
                     hitLsr ? lsrVal :
                     hitScr ? scratch_r : 8'h00;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      identTx_r <= 1'b0;
      irqOut <= 1'b0;
    end
    else
    begin
      irqOut <= (idCode != ID_NONE);
      if (setupPh)
      begin
        // snapshot freezes the identification for the access
        prdata <= {24'h000000, rdMux};
        pslverr <= ~mapped;
        identTx_r <= (idCode == ID_TXEMPTY);
      end
    end
  end
  assign pready = penable;

endmodule

// ### tb/ufi_fifo_irq_sva.sv
`timescale 1ns/1ps
module ufi_fifo_irq_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire ufi_pkg::ufi_addr_t paddr,
  input wire ufi_pkg::ufi_word_t prdata,
  input wire logic pslverr,
  input wire logic txPull,
  input wire logic txShiftBusy,
  input wire ufi_pkg::ufi_byte_t txByte,
  input wire logic txAvail
);
  import ufi_pkg::*;
  // ----------------
  // port checks
  // ----------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire rdAcc = psel && penable && !pwrite;
  wire stSetup = psel && !penable && !pwrite && paddr == OFS_LINE_STATUS;
  wire dataWr = psel && penable && pwrite && paddr == OFS_DATA;
  wire ctrlWr = psel && penable && pwrite && paddr == OFS_IDENT_FIFO_CTRL;
  upper_zero_a: assert property (rdAcc |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  bad_addr_a: assert property (psel && !penable && paddr > OFS_SCRATCH |=> pslverr)
    else $error("unmapped address without slave error");
  tx_rise_a: assert property ($rose(txAvail) |-> $past(dataWr))
    else $error("transmit data appeared without a data write");
  tx_fall_a: assert property ($fell(txAvail) |-> $past(txPull || ctrlWr))
    else $error("transmit data lost without pull or clear");
  hold_empty_a: assert property (stSetup |=> prdata[5] == !$past(txAvail))
    else $error("holding empty flag wrong");
  all_empty_a: assert property (stSetup |=> prdata[6] == !$past(txAvail || txShiftBusy))
    else $error("transmitter empty flag wrong");
  ident_shape_a: assert property (rdAcc && paddr == OFS_IDENT_FIFO_CTRL |->
    prdata[5:4] == 2'h0 && prdata[7] == prdata[6] && (prdata[2] || !prdata[3]))
    else $error("identification layout wrong");
  head_stable_a: assert property (txAvail && $past(txAvail) && !$past(txPull) |->
    $stable(txByte))
    else $error("transmit head changed without pull");
endmodule

bind ufi_fifo_irq ufi_fifo_irq_chk chk (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
  .prdata, .pslverr, .txPull, .txShiftBusy, .txByte, .txAvail);

// ### tb/ufi_line_model.sv
`timescale 1ns/1ps
module ufi_line_model (
  input wire logic clk_sys,
  output logic rclkPin,
  output logic rxPush,
  output ufi_pkg::ufi_byte_t rxByte,
  output logic rxParityErr,
  output logic rxFrameErr,
  output logic rxBreak,
  output logic txPull,
  output logic txShiftBusy,
  input wire ufi_pkg::ufi_byte_t txByte,
  input wire logic txAvail
);
  import ufi_pkg::*;
  ufi_byte_t lastTx;
  int busyCnt;
  // ----------------
  // free running receiver clock, six system cycles a tick
  // ----------------
  initial
  begin
    {rxPush, rxParityErr, rxFrameErr, rxBreak, txPull, txShiftBusy} = 6'h00;
    rxByte = 8'h00;
    lastTx = 8'h00;
    busyCnt = 0;
    rclkPin = 1'b0;
    forever #300 rclkPin = ~rclkPin;
  end
  // idle lines carry inverted junk so nothing passes by luck
  task send(input ufi_byte_t b, input logic [2:0] e);
    @(posedge clk_sys);
    rxPush <= 1'b1;
    rxByte <= b;
    {rxBreak, rxFrameErr, rxParityErr} <= e;
    @(posedge clk_sys);
    rxPush <= 1'b0;
    rxByte <= ~b;
    {rxBreak, rxFrameErr, rxParityErr} <= ~e;
  endtask
  // shifter takes a byte, then stays busy for a while
  always @(posedge clk_sys)
  begin
    txPull <= 1'b0;
    txShiftBusy <= txPull || busyCnt > 1;
    if (busyCnt > 0)
      busyCnt <= busyCnt - 1;
    else if (txAvail && !txPull)
    begin
      txPull <= 1'b1;
      lastTx <= txByte;
      busyCnt <= 20;
    end
  end
endmodule

// ### tb/test_uart_fifo_interrupt_logic.sv
`timescale 1ns/1ps
module test_uart_fifo_interrupt_logic;
  import ufi_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, rclkPin, rxPush;
  logic rxParityErr, rxFrameErr, rxBreak, txPull, txShiftBusy, txAvail, irqOut, errQ;
  ufi_addr_t paddr;
  ufi_word_t pwdata, prdata;
  ufi_byte_t rxByte, txByte, q, tl;
  ufi_byte_t trig [4] = '{8'h01, 8'h04, 8'h08, 8'h0e};
  logic [2:0] e;
  int n_fail, total_checks;
  ufi_fifo_irq DUT (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .rclkPin, .rxPush, .rxByte, .rxParityErr, .rxFrameErr, .rxBreak,
    .txPull, .txShiftBusy, .txByte, .txAvail, .irqOut);
  ufi_line_model line (.clk_sys, .rclkPin, .rxPush, .rxByte, .rxParityErr, .rxFrameErr,
    .rxBreak, .txPull, .txShiftBusy, .txByte, .txAvail);
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ----------------
  // helpers
  // ----------------
  task final_report;
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input ufi_addr_t a, input logic w, input ufi_byte_t d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_fail++;
      final_report();
    end
    q = prdata[7:0];
    errQ = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input ufi_addr_t a, input ufi_byte_t x, input string nm);
    apb(a, 1'b0, 8'h00);
    chk(nm, q, x);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task irq(input logic x);
    chk("irq", {7'h0, irqOut}, {7'h0, x});
  endtask
  task wirq(input int lim);
    int n;
    n = 0;
    while (irqOut !== 1'b1 && n < lim)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= lim)
    begin
      n_fail++;
      final_report();
    end
  endtask
  // ----------------
  // sequence
  // ----------------
  initial
  begin
    {rst, psel, penable, pwrite} = 4'h8;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    total_checks = 0;
    cyc(10);
    rst <= 1'b0;
    rdc(OFS_SCRATCH, 8'h00, "scratch");
    apb(OFS_SCRATCH, 1'b1, 8'ha5);
    rdc(OFS_SCRATCH, 8'ha5, "scratch");
    apb(8'h40, 1'b0, 8'h00);
    chk("slverr", {7'h0, errQ}, 8'h01);
    for (int c = 0; c < 4; c++)
    begin
      tl = trig[c];
      apb(OFS_IDENT_FIFO_CTRL, 1'b1, {c[1:0], 6'h07});
      apb(OFS_IRQ_ENABLE, 1'b1, 8'h01);
      for (ufi_byte_t k = 8'h01; k < tl; k++) line.send(8'h2f + k, 3'h0);
      cyc(3);
      irq(1'b0);
      line.send(8'h2f + tl, 3'h0);
      cyc(3);
      irq(1'b1);
      rdc(OFS_IDENT_FIFO_CTRL, 8'hc4, "ident");
      rdc(OFS_DATA, 8'h30, "rxhead");
      cyc(3);
      irq(1'b0);
      rdc(OFS_IDENT_FIFO_CTRL, 8'hc1, "ident");
    end
    apb(OFS_IDENT_FIFO_CTRL, 1'b1, 8'hc7);
    line.send(8'h41, 3'h0);
    cyc(2400);
    line.send(8'h42, 3'h0);
    cyc(2400);
    irq(1'b0);
    wirq(1800);
    irq(1'b1);
    rdc(OFS_IDENT_FIFO_CTRL, 8'hcc, "ident");
    rdc(OFS_DATA, 8'h41, "rxhead");
    cyc(3);
    irq(1'b0);
    apb(OFS_IRQ_ENABLE, 1'b1, 8'h00);
    apb(OFS_IDENT_FIFO_CTRL, 1'b1, 8'h01);
    cyc(3);
    irq(1'b0);
    rdc(OFS_IDENT_FIFO_CTRL, 8'hc1, "ident");
    rdc(OFS_LINE_STATUS, 8'h61, "status");
    rdc(OFS_DATA, 8'h42, "rxhead");
    rdc(OFS_LINE_STATUS, 8'h60, "status");
    apb(OFS_IRQ_ENABLE, 1'b1, 8'h02);
    cyc(3);
    irq(1'b1);
    rdc(OFS_IDENT_FIFO_CTRL, 8'hc2, "ident");
    cyc(3);
    irq(1'b0);
    apb(OFS_DATA, 1'b1, 8'h5a);
    cyc(40);
    chk("txbyte", line.lastTx, 8'h5a);
    irq(1'b0);
    wirq(1200);
    irq(1'b1);
    // the shifter drains the first byte at once, so a third write is needed
    // to have two bytes held together while the shifter is busy
    apb(OFS_DATA, 1'b1, 8'h11);
    apb(OFS_DATA, 1'b1, 8'h22);
    apb(OFS_DATA, 1'b1, 8'h44);
    wirq(100);
    irq(1'b1);
    chk("txbyte", line.lastTx, 8'h44);
    apb(OFS_IDENT_FIFO_CTRL, 1'b1, 8'h00);
    apb(OFS_IDENT_FIFO_CTRL, 1'b1, 8'h01);
    apb(OFS_DATA, 1'b1, 8'h33);
    cyc(40);
    irq(1'b1);
    apb(OFS_IDENT_FIFO_CTRL, 1'b1, 8'h07);
    apb(OFS_IRQ_ENABLE, 1'b1, 8'h05);
    for (e = 3'h1; e != 3'h0; e = e << 1)
    begin
      line.send(8'h60, e);
      cyc(3);
      irq(1'b1);
      rdc(OFS_IDENT_FIFO_CTRL, 8'hc6, "ident");
      rdc(OFS_LINE_STATUS, 8'he1 | {3'h0, e, 2'h0}, "status");
      rdc(OFS_DATA, 8'h60, "rxhead");
      rdc(OFS_LINE_STATUS, 8'h60, "status");
    end
    final_report();
  end
endmodule
